// File: hw/brie_defs.svh
// Constants of the byte-register instruction executor
// How it works
// - 000111da ffffffff complements f, sets N,Z
// - 0110001a compare-skip, flags untouched
// - Unsigned f minus W; equal flushes next fetch
// - Skip costs one or two extra cycles
// - 010000da ffffffff rotates right, sets N,Z
// - Bit n to n-1, bit 0 to 7
// - d=0 writes W, d=1 writes f
// - 0110100a writes FFh to f, flags untouched
// - a=0, extended set, f<=5Fh uses indexed offset
// - Instruction cycle is four clock phases
`ifndef BRIE_DEFS_SVH
`define BRIE_DEFS_SVH
`define BRIE_OPC_COMP 6'h07
`define BRIE_OPC_CMPS 7'h31
`define BRIE_OPC_ROTR 6'h10
`define BRIE_OPC_FILL 7'h34
`define BRIE_SKIP_NONE 2'h0
`define BRIE_SKIP_SECOND 2'h1
`define BRIE_SKIP_FIRST 2'h2
`define BRIE_OPC_HI6 15:10
`define BRIE_OPC_HI7 15:9
`define BRIE_BIT_D 9
`define BRIE_BIT_A 8
`define BRIE_FLD_F 7:0
`define BRIE_IDX_LIMIT 8'h5f
`define BRIE_ACC_SPLIT 8'h60
`define BRIE_ACC_HI_BANK 4'hf
`define BRIE_ALL_ONES 8'hff
`define BRIE_ZERO8 8'h00
`define BRIE_PHASES 2'h3
`define BRIE_TWO_WORD_HI 4'hf
`define BRIE_PH_BITS 15:12
`endif

// File: hw/brie_pkg.sv
// Types of the byte-register instruction executor
package brie_pkg;
   typedef enum logic [2:0] {
      BRIE_OP_NONE = 3'h0,
      BRIE_OP_COMP = 3'h1,
      BRIE_OP_CMPS = 3'h2,
      BRIE_OP_ROTR = 3'h3,
      BRIE_OP_FILL = 3'h4
   } brie_op_t;
   typedef enum logic [1:0] {
      BRIE_Q1 = 2'b00,
      BRIE_Q2 = 2'b01,
      BRIE_Q3 = 2'b11,
      BRIE_Q4 = 2'b10
   } brie_phase_t;
endpackage

// File: hw/brie_phase_gen.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module brie_phase_gen
   import brie_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   output brie_pkg::brie_phase_t phase_o
);
   brie_phase_t phase_r, phase_nxt;

   // Gray order, one clock per phase
   always_comb begin
      case (phase_r)
         BRIE_Q1: phase_nxt = BRIE_Q2;
         BRIE_Q2: phase_nxt = BRIE_Q3;
         BRIE_Q3: phase_nxt = BRIE_Q4;
         BRIE_Q4: phase_nxt = BRIE_Q1;
         default: phase_nxt = BRIE_Q1;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r <= BRIE_Q1;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   assign phase_o = phase_r;
endmodule // brie_phase_gen
`default_nettype wire

// File: hw/brie_decode.sv
// Opcode decoder and address former
`include "brie_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module brie_decode
   import brie_pkg::*;
(
   input wire logic [15:0] instr_i,
   input wire logic ext_set_i,
   input wire logic [3:0] bank_select_register_i,
   input wire logic [11:0] fsr2_i,
   output brie_pkg::brie_op_t op_o,
   output logic dest_f_o,
   output logic [11:0] addr_o
);
   logic [7:0] f;
   logic acc;
   assign f = instr_i[`BRIE_FLD_F];
   assign acc = instr_i[`BRIE_BIT_A];

   always_comb begin
      op_o = BRIE_OP_NONE;
      dest_f_o = 1'b0;
      if (instr_i[`BRIE_OPC_HI6] == `BRIE_OPC_COMP) begin
         op_o = BRIE_OP_COMP;
         dest_f_o = instr_i[`BRIE_BIT_D];
      end else if (instr_i[`BRIE_OPC_HI6] == `BRIE_OPC_ROTR) begin
         op_o = BRIE_OP_ROTR;
         dest_f_o = instr_i[`BRIE_BIT_D];
      end else if (instr_i[`BRIE_OPC_HI7] == `BRIE_OPC_CMPS) begin
         op_o = BRIE_OP_CMPS;
      end else if (instr_i[`BRIE_OPC_HI7] == `BRIE_OPC_FILL) begin
         op_o = BRIE_OP_FILL;
         dest_f_o = 1'b1;
      end
   end

   always_comb begin
      if (!acc && ext_set_i && f <= `BRIE_IDX_LIMIT) begin
         addr_o = fsr2_i + {4'h0, f};
      end else if (!acc) begin
         // Access bank: low part of bank 0 or top of bank 15
         addr_o = (f < `BRIE_ACC_SPLIT) ? {4'h0, f}
                                        : {`BRIE_ACC_HI_BANK, f};
      end else begin
         addr_o = {bank_select_register_i, f};
      end
   end
endmodule // brie_decode
`default_nettype wire

// File: hw/brie_exec.sv
// Execute unit for complement, compare-skip, rotate and fill
`include "brie_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module brie_exec
   import brie_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   // Instruction stream
   input wire logic [15:0] INSTR_I,
   input wire logic EXT_SET_I,
   input wire logic [3:0] BANK_SELECT_REGISTER_I,
   input wire logic [11:0] FSR2_I,
   // Register file read
   input wire logic [7:0] RD_DATA_I,
   output logic [11:0] ADDR_O,
   // Register file write
   output logic WR_EN_O,
   output logic [7:0] WR_DATA_O,
   // Working register and flags
   output logic [7:0] W_O,
   output logic FLAG_N_O,
   output logic FLAG_Z_O,
   // Cycle status
   output logic CYCLE_END_O,
   output logic FLUSH_O
);
   import brie_pkg::*;

   // ----------------------------------------
   // Phase and decode
   // ----------------------------------------
   brie_phase_t phase;
   brie_op_t op;
   logic dest_f;
   logic [11:0] addr;

   brie_phase_gen u_phase (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .phase_o(phase)
   );

   brie_decode u_dec (
      .instr_i(INSTR_I),
      .ext_set_i(EXT_SET_I),
      .bank_select_register_i(BANK_SELECT_REGISTER_I),
      .fsr2_i(FSR2_I),
      .op_o(op),
      .dest_f_o(dest_f),
      .addr_o(addr)
   );

   // ----------------------------------------
   // Datapath state
   // ----------------------------------------
   brie_op_t op_r, op_nxt;
   logic dest_r, dest_nxt;
   logic [11:0] addr_r, addr_nxt;
   logic [7:0] opnd_r, opnd_nxt;
   logic [7:0] res_r, res_nxt;
   logic [7:0] w_r, w_nxt;
   logic n_r, n_nxt;
   logic z_r, z_nxt;
   logic wr_r, wr_nxt;
   logic [7:0] wd_r, wd_nxt;
   logic end_r, end_nxt;
   logic flush_r, flush_nxt;
   logic [1:0] skip_r, skip_nxt;
   logic nop_r, nop_nxt;
   logic two_word;

   // Long-form second word starts with all ones in the top nibble
   assign two_word = (INSTR_I[`BRIE_PH_BITS] == `BRIE_TWO_WORD_HI);

   always_comb begin
      op_nxt = op_r;
      dest_nxt = dest_r;
      addr_nxt = addr_r;
      opnd_nxt = opnd_r;
      res_nxt = res_r;
      w_nxt = w_r;
      n_nxt = n_r;
      z_nxt = z_r;
      wr_nxt = 1'b0;
      wd_nxt = wd_r;
      end_nxt = 1'b0;
      flush_nxt = flush_r;
      skip_nxt = skip_r;
      nop_nxt = nop_r;
      case (phase)
         BRIE_Q1: begin
            // Decode; a flushed slot becomes a no-operation
            // Continuation word after a skipped slot is flushed too
            if (skip_r == `BRIE_SKIP_FIRST) begin
               nop_nxt = 1'b1;
               skip_nxt = `BRIE_SKIP_SECOND;
            end else if (skip_r == `BRIE_SKIP_SECOND) begin
               nop_nxt = two_word;
               skip_nxt = `BRIE_SKIP_NONE;
            end else begin
               nop_nxt = 1'b0;
            end
            op_nxt = nop_nxt ? BRIE_OP_NONE : op;
            dest_nxt = dest_f;
            addr_nxt = addr;
         end
         BRIE_Q2: begin
            opnd_nxt = RD_DATA_I;
            addr_nxt = addr_r;
         end
         BRIE_Q3: begin
            case (op_r)
               BRIE_OP_COMP: res_nxt = ~opnd_r;
               BRIE_OP_ROTR: res_nxt = {opnd_r[0], opnd_r[7:1]};
               BRIE_OP_FILL: res_nxt = `BRIE_ALL_ONES;
               default: res_nxt = opnd_r;
            endcase
            if (op_r == BRIE_OP_CMPS && opnd_r - w_r == `BRIE_ZERO8) begin
               skip_nxt = `BRIE_SKIP_FIRST;
            end
         end
         BRIE_Q4: begin
            end_nxt = 1'b1;
            // Marks the slot that just ended, not the compare itself
            flush_nxt = nop_r;
            if (op_r == BRIE_OP_COMP || op_r == BRIE_OP_ROTR) begin
               n_nxt = res_r[7];
               z_nxt = (res_r == `BRIE_ZERO8);
            end
            if (op_r == BRIE_OP_COMP || op_r == BRIE_OP_ROTR ||
                op_r == BRIE_OP_FILL) begin
               if (dest_r) begin
                  wr_nxt = 1'b1;
                  wd_nxt = res_r;
               end else begin
                  w_nxt = res_r;
               end
            end
         end
         default: begin
            op_nxt = BRIE_OP_NONE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         op_r <= BRIE_OP_NONE;
         dest_r <= 1'b0;
         addr_r <= 12'h000;
         opnd_r <= 8'h00;
         res_r <= 8'h00;
         w_r <= 8'h00;
         n_r <= 1'b0;
         z_r <= 1'b0;
         wr_r <= 1'b0;
         wd_r <= 8'h00;
         end_r <= 1'b0;
         flush_r <= 1'b0;
         skip_r <= 2'h0;
         nop_r <= 1'b0;
      end else begin
         op_r <= op_nxt;
         dest_r <= dest_nxt;
         addr_r <= addr_nxt;
         opnd_r <= opnd_nxt;
         res_r <= res_nxt;
         w_r <= w_nxt;
         n_r <= n_nxt;
         z_r <= z_nxt;
         wr_r <= wr_nxt;
         wd_r <= wd_nxt;
         end_r <= end_nxt;
         flush_r <= flush_nxt;
         skip_r <= skip_nxt;
         nop_r <= nop_nxt;
      end
   end

   assign ADDR_O = addr_r;
   assign WR_EN_O = wr_r;
   assign WR_DATA_O = wd_r;
   assign W_O = w_r;
   assign FLAG_N_O = n_r;
   assign FLAG_Z_O = z_r;
   assign CYCLE_END_O = end_r;
   assign FLUSH_O = flush_r;
endmodule // brie_exec
`default_nettype wire

// File: test/brie_exec_asserts.sv
// Assertions on the executor's top-level ports
`timescale 1ns/1ps
`default_nettype none
module brie_exec_asserts (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   // Stimulus seen
   input wire logic [15:0] INSTR_I,
   input wire logic [7:0] RD_DATA_I,
   // Results
   input wire logic WR_EN_O,
   input wire logic [7:0] WR_DATA_O,
   input wire logic [7:0] W_O,
   input wire logic FLAG_N_O,
   input wire logic FLAG_Z_O,
   input wire logic CYCLE_END_O,
   input wire logic FLUSH_O
);
   // Word and operand two edges back belong to the ending cycle
   logic [15:0] i1, i2;
   logic [7:0] r1, r2;
   always_ff @(posedge SYS_CLK_I) begin
      i1 <= INSTR_I;
      i2 <= i1;
      r1 <= RD_DATA_I;
      r2 <= r1;
   end
   wire logic wr = CYCLE_END_O && WR_EN_O;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence s_gap;
      !CYCLE_END_O [*3] ##1 CYCLE_END_O;
   endsequence
   a_cycle_four: assert property (CYCLE_END_O |=> s_gap)
      else $error("Cycle end spacing wrong");
   a_wr_pulse: assert property (WR_EN_O |->
      CYCLE_END_O ##1 !WR_EN_O)
      else $error("Write pulse wrong");
   a_comp_data: assert property (wr && i2[15:10] == 6'h07 |->
      WR_DATA_O == ~r2 && FLAG_N_O == WR_DATA_O[7])
      else $error("Complement result wrong");
   a_rot_data: assert property (wr && i2[15:10] == 6'h10 |->
      WR_DATA_O == {r2[0], r2[7:1]} && FLAG_Z_O == (WR_DATA_O == 8'h00))
      else $error("Rotate result wrong");
   a_fill_ones: assert property (wr && i2[15:9] == 7'h34 |->
      WR_DATA_O == 8'hff)
      else $error("Fill data wrong");
   a_cmp_quiet: assert property (CYCLE_END_O && i2[15:9] == 7'h31
      |-> !WR_EN_O && $stable(W_O) && $stable(FLAG_Z_O) && $stable(FLAG_N_O))
      else $error("Compare changed state");
   a_dest_w: assert property (CYCLE_END_O && !i2[9] &&
      (i2[15:10] == 6'h07 || i2[15:10] == 6'h10) |-> !WR_EN_O)
      else $error("Write with d clear");
   a_flush_quiet: assert property (CYCLE_END_O && FLUSH_O |->
      !WR_EN_O && $stable(W_O))
      else $error("Flushed slot acted");
   // Executed compare that found its operand equal to W
   sequence s_cmp_hit;
      CYCLE_END_O && !FLUSH_O && i2[15:9] == 7'h31 && r2 == W_O;
   endsequence
   sequence s_flushed_end;
      CYCLE_END_O && FLUSH_O;
   endsequence
   a_skip_next: assert property (s_cmp_hit |-> ##4 s_flushed_end)
      else $error("Skipped slot not flushed");
endmodule // brie_exec_asserts
`default_nettype wire

// File: test/brie_exec_bench.sv
// Self-checking bench for the byte-register instruction executor
`timescale 1ns/1ps
`default_nettype none
module brie_exec_bench;
   import brie_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] instr = 16'h0000;
   logic ext = 1'b0;
   logic [3:0] bank = 4'h3;
   logic [11:0] fsr2 = 12'h200;
   logic [7:0] rd = 8'h00;
   logic [11:0] addr, ca;
   logic we, n, z, ce, fl, pwe, pn, pz, pce, pfl;
   logic [7:0] wd, w, pwd, pw;
   int err_count = 0;
   int n_compared = 0;
   always #10 clk = ~clk;
   brie_exec i_brie_exec (.SYS_CLK_I(clk), .SYS_RST_I(rst), .INSTR_I(instr),
      .EXT_SET_I(ext), .BANK_SELECT_REGISTER_I(bank), .FSR2_I(fsr2),
      .RD_DATA_I(rd), .ADDR_O(addr), .WR_EN_O(we), .WR_DATA_O(wd), .W_O(w),
      .FLAG_N_O(n), .FLAG_Z_O(z), .CYCLE_END_O(ce), .FLUSH_O(fl));
   task automatic chk(string s, logic [11:0] e, logic [11:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   // One four-clock slot; p* hold what the previous slot left
   task automatic slot(logic [15:0] i, logic [7:0] r);
      // Pulses of the last slot stand only until this slot's first edge
      {pwe, pwd, pw, pn, pz, pce, pfl} = {we, wd, w, n, z, ce, fl};
      instr = i;
      rd = r;
      repeat (2) @(negedge clk);
      if (i !== 16'h0000) ca = addr;
      repeat (2) @(negedge clk);
   endtask
   task automatic op(logic [15:0] i, logic [7:0] r);
      slot(i, r);
      slot(16'h0000, 8'h00);
   endtask
   task automatic t_rot();
      op(16'h4342, 8'hd7);
      chk("rot data", 8'heb, pwd);
      chk("rot neg", 1, pn);
      chk("cycle end", 1, pce);
      op(16'h4142, 8'h01);
      chk("rot w", 8'h80, pw);
   endtask
   task automatic t_comp();
      op(16'h1f21, 8'h13);
      chk("comp data", 8'hec, pwd);
      chk("comp wr", 1, pwe);
      chk("bank addr", 12'h321, ca);
      op(16'h1d21, 8'hff);
      chk("comp w", 8'h00, pw);
      chk("comp nowr", 0, pwe);
      chk("comp zero", 1, pz);
   endtask
   task automatic t_fill();
      op(16'h6955, 8'h00);
      chk("fill data", 8'hff, pwd);
      chk("fill zero", 1, pz);
      chk("fill neg", 0, pn);
   endtask
   task automatic t_cmp();
      slot(16'h6310, 8'h01);
      slot(16'h6911, 8'h00);
      chk("cmp zero", 1, pz);
      slot(16'h6310, 8'h00);
      chk("no skip", 1, pwe);
      slot(16'h6912, 8'h00);
      slot(16'h6913, 8'h00);
      chk("skip flush", 1, pfl);
      chk("skip nowr", 0, pwe);
      slot(16'h6310, 8'h00);
      chk("after skip", 1, pwe);
      slot(16'hc0aa, 8'h00);
      slot(16'hf0bb, 8'h00);
      chk("flush one", 1, pfl);
      slot(16'h6914, 8'h00);
      chk("flush two", 1, pfl);
      slot(16'h0000, 8'h00);
      chk("resume", 1, pwe);
   endtask
   task automatic t_addr();
      logic [20:0] t [4] = '{{1'b0, 8'h5f, 12'h05f}, {1'b0, 8'h60, 12'hf60},
         {1'b1, 8'h5f, 12'h25f}, {1'b1, 8'h60, 12'hf60}};
      foreach (t[k]) begin
         ext = t[k][20];
         op({8'h68, t[k][19:12]}, 8'h00);
         chk("addr", t[k][11:0], ca);
      end
      ext = 1'b0;
   endtask
   task automatic end_sim();
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Whole run is about 120 cycles
   initial begin
      #20000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_rot();
      t_comp();
      t_fill();
      t_cmp();
      t_addr();
      end_sim();
   end
endmodule // brie_exec_bench
bind brie_exec brie_exec_asserts i_brie_exec_asserts (.SYS_CLK_I,
   .SYS_RST_I, .INSTR_I, .RD_DATA_I, .WR_EN_O, .WR_DATA_O, .W_O,
   .FLAG_N_O, .FLAG_Z_O, .CYCLE_END_O, .FLUSH_O);
`default_nettype wire
